// File: core/lrcs_map.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the core module
`ifndef LRCS_MAP_SVH
`define LRCS_MAP_SVH

// byte offsets of the apb registers
`define LRCS_CTRL_OFF        12'h000
`define LRCS_STAT_OFF        12'h004
`define LRCS_PWMAX_OFF       12'h008
`define LRCS_DUTY_OFF        12'h00c

// control register fields
`define LRCS_CTRL_REFL_BIT   0
`define LRCS_CTRL_PROT_BIT   1
`define LRCS_CTRL_LFLT_BIT   2

// status register fields
`define LRCS_STAT_FAULT_BIT  0
`define LRCS_STAT_OVL_BIT    1
`define LRCS_STAT_REFL_BIT   2
`define LRCS_STAT_EMIT_BIT   3
`define LRCS_STAT_EN_BIT     4
`define LRCS_STAT_GATE_BIT   5

// reset values
`define LRCS_CTRL_RST        3'h2
`define LRCS_PWMAX_RST       32'h0000_c350
`define LRCS_DUTY_RST        7'h3c

// duty window: 1 ms at 50 MHz, counted as 50000 cycles
`define LRCS_WIN_US          1000
`define LRCS_CLK_MHZ         50
`define LRCS_WIN_CYC         (`LRCS_WIN_US * `LRCS_CLK_MHZ)

`endif

// File: core/lrcs_pkg.sv
// types shared by the laser control block
// assumes lrcs_map.svh lies beside it
package lrcs_pkg;
  // enable line tracking for fault clear
  typedef enum logic [1:0] {
    LRCS_EN_ARMED,
    LRCS_EN_FAULTED,
    LRCS_EN_OPENED
  } lrcs_en_t;
endpackage : lrcs_pkg

// File: core/lrcs_core.sv
// real-time control and status logic of a pulsed rf laser
// assumes inputs synchronous to clk, software on apb, analog sensing
// reduced to a reflected-over-limit level input
//
// Summary of operation
// - no emission unless the enable input is asserted.
// - a fault clears only when enable is opened then closed again.
// - the fault output is high exactly while a fault is latched.
// - emission only while gate is high, never longer than the pulse.
// - overlimit warns only over the part beyond duty or width limit.
// - reflection warns only while reflection is high and protected.
// - emission is inhibited exactly while a warning is high.
// - both warnings stay low for an in-limit gated pulse.
// - both warnings stay low while gate is low.
// - a latching fault stops emission at once and stays latched.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "lrcs_map.svh"

module lrcs_core
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        enable_n,
  input  wire logic        gate,
  input  wire logic        refl_over,
  input  wire logic        latch_fault_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             emit,
  output logic             system_fault,
  output logic             overlimit_warn,
  output logic             reflection_protect_warn
);

  logic [1:0]       en_sync_q;
  logic [1:0]       gate_sync_q;
  logic             en_q;
  logic             gate_q;
  logic             fault_q;
  lrcs_pkg::lrcs_en_t en_st_q;
  logic [2:0]       ctrl_q;
  logic [31:0]      pwmax_q;
  logic [6:0]       duty_q;
  logic [31:0]      pw_cnt_q;
  logic [31:0]      win_cnt_q;
  logic [31:0]      on_cnt_q;
  logic             over_pw;
  logic             over_duty;
  logic             fault_src;
  logic             en_rise;
  logic             wr_en;

  // checks run on clk and sleep while reset is high
  default clocking lrcs_cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // resample chain; enable is used from the second stage, gate from the third stage gate_q
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      en_sync_q   <= 2'h0;
      gate_sync_q <= 2'h0;
      en_q        <= 1'b0;
      gate_q      <= 1'b0;
    end
    else
    begin
      en_sync_q   <= {en_sync_q[0], ~enable_n};
      gate_sync_q <= {gate_sync_q[0], gate};
      en_q        <= en_sync_q[1];
      gate_q      <= gate_sync_q[1];
    end
  end

  assign en_rise   = en_sync_q[1] & ~en_q;
  assign fault_src = latch_fault_in | ctrl_q[`LRCS_CTRL_LFLT_BIT];

  // fault latch: open then close of enable clears; new fault wins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fault_q <= 1'b0;
      en_st_q <= lrcs_pkg::LRCS_EN_ARMED;
    end
    else
    begin
      case (en_st_q)
        lrcs_pkg::LRCS_EN_ARMED:
        begin
          if (fault_src)
          begin
            fault_q <= 1'b1;
            en_st_q <= lrcs_pkg::LRCS_EN_FAULTED;
          end
        end
        lrcs_pkg::LRCS_EN_FAULTED:
        begin
          if (!en_sync_q[1] && !fault_src)
            en_st_q <= lrcs_pkg::LRCS_EN_OPENED;
        end
        lrcs_pkg::LRCS_EN_OPENED:
        begin
          if (fault_src)
            en_st_q <= lrcs_pkg::LRCS_EN_FAULTED;
          else if (en_rise)
          begin
            fault_q <= 1'b0;
            en_st_q <= lrcs_pkg::LRCS_EN_ARMED;
          end
        end
        default:
          en_st_q <= lrcs_pkg::LRCS_EN_FAULTED;
      endcase
    end
  end

  assign system_fault = fault_q;

  // width counter runs over each gated pulse, cleared between pulses
  always_ff @(posedge clk)
  begin
    if (sys_rst || !gate_q)
      pw_cnt_q <= 32'h0;
    else if (pw_cnt_q != 32'hffff_ffff)
      pw_cnt_q <= pw_cnt_q + 32'h1;
  end

  // block duty measure over a fixed window, both counts cleared at its end
  always_ff @(posedge clk)
  begin
    if (sys_rst || win_cnt_q == `LRCS_WIN_CYC - 1)
    begin
      win_cnt_q <= 32'h0;
      on_cnt_q  <= 32'h0;
    end
    else
    begin
      win_cnt_q <= win_cnt_q + 32'h1;
      if (emit)
        on_cnt_q <= on_cnt_q + 32'h1;
    end
  end

  // on-time limit in the window is duty percent of window length
  assign over_pw   = pw_cnt_q >= pwmax_q;
  assign over_duty = (on_cnt_q * 32'h64) >=
                     (32'(duty_q) * 32'(`LRCS_WIN_CYC));

  // warnings gated by gate so they are low outside pulses
  assign overlimit_warn = gate_q & (over_pw | over_duty);
  assign reflection_protect_warn = gate_q & refl_over &
                                   ctrl_q[`LRCS_CTRL_PROT_BIT];

  // emission: gated, enabled, fault-free, not inhibited
  assign emit = gate_q & en_sync_q[1] & ~fault_q & ~fault_src &
                ~overlimit_warn & ~reflection_protect_warn;

  // apb: zero wait states, slverr on unmapped offsets
  assign pready = 1'b1;
  assign wr_en  = psel & penable & pwrite;
  assign pslverr = psel & penable & !(paddr == `LRCS_CTRL_OFF ||
                   paddr == `LRCS_STAT_OFF || paddr == `LRCS_PWMAX_OFF ||
                   paddr == `LRCS_DUTY_OFF);

  // software-written limits and control
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_q  <= `LRCS_CTRL_RST;
      pwmax_q <= `LRCS_PWMAX_RST;
      duty_q  <= `LRCS_DUTY_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        `LRCS_CTRL_OFF:  ctrl_q  <= pwdata[2:0];
        `LRCS_PWMAX_OFF: pwmax_q <= pwdata;
        `LRCS_DUTY_OFF:  duty_q  <= pwdata[6:0];
        default:         ctrl_q  <= ctrl_q;
      endcase
    end
  end

  // read data registered during setup, valid in the access phase
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      prdata <= 32'h0;
    else if (psel && !penable)
    begin
      case (paddr)
        `LRCS_CTRL_OFF:  prdata <= {29'h0, ctrl_q};
        `LRCS_STAT_OFF:  prdata <= {26'h0, gate_q, en_sync_q[1], emit,
                                    reflection_protect_warn,
                                    overlimit_warn, fault_q};
        `LRCS_PWMAX_OFF: prdata <= pwmax_q;
        `LRCS_DUTY_OFF:  prdata <= {25'h0, duty_q};
        default:         prdata <= 32'h0;
      endcase
    end
  end

  // pin-referenced checks: gate lands in gate_q three edges late,
  // enable in the second resample stage two edges late
  a_warn_low_idle: assert property (
    !gate_q |-> !overlimit_warn && !reflection_protect_warn)
    else $error("warning high with gate low");
  a_emit_needs_en: assert property (
    emit |-> $past(!enable_n, 2))
    else $error("emission without enable");
  a_emit_in_gate: assert property (
    emit |-> $past(gate, 3))
    else $error("emission outside pulse");
  a_warn_inhibits: assert property (
    (overlimit_warn || reflection_protect_warn) |-> !emit)
    else $error("emission during warning");
  a_refl_warn: assert property (
    reflection_protect_warn == ($past(gate, 3) && refl_over &&
                                ctrl_q[`LRCS_CTRL_PROT_BIT]))
    else $error("reflection warning mismatch");
  a_ovl_pw: assert property (
    gate_q && pw_cnt_q < pwmax_q && !over_duty |-> !overlimit_warn)
    else $error("overlimit without cause");
  a_fault_set: assert property (
    fault_src |=> system_fault && !emit)
    else $error("fault not latched");
  a_fault_hold: assert property (
    system_fault && !en_rise |=> system_fault)
    else $error("fault cleared without enable cycle");
  a_ok_quiet: assert property (
    gate_q && !over_pw && !over_duty && !refl_over |->
    !overlimit_warn && !reflection_protect_warn)
    else $error("warning with in-limit pulse");
  a_sync_edge: assert property (
    en_rise |-> $past(!enable_n, 2) && !$past(en_sync_q[0], 2))
    else $error("enable edge mis-detected");
  a_fault_out: assert property (
    system_fault == fault_q && !(system_fault && emit))
    else $error("fault output mismatch");

  c_emit: cover property (emit);
  c_ovl: cover property (emit ##1 overlimit_warn);
  c_clear: cover property (system_fault ##1 !system_fault);

endmodule : lrcs_core

// File: tb/lrcs_host.sv
// host side model driving the enable and gating lines
// assumes the bench calls set_lines right after a clock edge
`timescale 1ns/100ps

module lrcs_host
(
  input  wire logic clk,
  output logic      enable_n,
  output logic      gate
);
  logic supply_up = 1'b0;

  // enable held open until supply is up, gate low
  initial
  begin
    enable_n = 1'b1;
    gate     = 1'b0;
  end

  // supply counts as up from the first edge; enable waits for it
  always @(posedge clk)
    supply_up <= 1'b1;

  // pulse widths are chosen by the caller within range; warnings are
  // read with gate high and with gate low; enable interlocks emission
  task automatic set_lines(input logic en_n, input logic g);
    enable_n <= en_n | ~supply_up;
    gate     <= g;
  endtask : set_lines
endmodule : lrcs_host

// File: tb/laser_realtime_control_status_bench.sv
// self-checking bench for the laser control block
// assumes design and host model compiled before it
`timescale 1ns/100ps

module laser_realtime_control_status_bench;
  logic        clk = 1'b0;
  logic        sys_rst, refl_over, latch_fault_in;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        emit, system_fault, ovl, refl, enable_n, gate;
  int          mismatches = 0;
  int          cmp_count  = 0;
  int          ticks      = 0;

  lrcs_core u_dut (.clk(clk), .sys_rst(sys_rst), .enable_n(enable_n),
    .gate(gate), .refl_over(refl_over), .latch_fault_in(latch_fault_in),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .emit(emit), .system_fault(system_fault), .overlimit_warn(ovl),
    .reflection_protect_warn(refl));
  lrcs_host u_host (.clk(clk), .enable_n(enable_n), .gate(gate));

  // 50 mhz clock
  always #10 clk = ~clk;

  // hang guard, well above the under 200 cycles used
  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 5000)
    begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    r   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge so a following call never re-raises psel at once
    @(posedge clk);
  endtask : apb

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  initial
  begin
    {sys_rst, refl_over, latch_fault_in} = 3'h4;
    {psel, penable, pwrite} = 3'h0;
    paddr  = 12'h000;
    pwdata = 32'h0;
    cyc(3);
    sys_rst <= 1'b0;
    // reset values and an unmapped offset
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", 32'h2, r);
    apb(1'b0, 12'h008, 32'h0);
    chk("pwmax", 32'hc350, r);
    apb(1'b0, 12'h00c, 32'h0);
    chk("duty", 32'h3c, r);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("test registers done");
    // gate with enable open must stay dark
    u_host.set_lines(1'b1, 1'b1);
    cyc(6);
    chk("emit open", 32'h0, {31'h0, emit});
    u_host.set_lines(1'b0, 1'b0);
    cyc(4);
    u_host.set_lines(1'b0, 1'b1);
    cyc(5);
    chk("emit on", 32'h1, {31'h0, emit});
    chk("warns in limit", 32'h0, {30'h0, ovl, refl});
    u_host.set_lines(1'b0, 1'b0);
    cyc(5);
    chk("emit off", 32'h0, {31'h0, emit});
    chk("warns gate low", 32'h0, {30'h0, ovl, refl});
    $display("test enable done");
    // short width limit trips the overlimit warning mid-pulse
    apb(1'b1, 12'h008, 32'ha);
    apb(1'b0, 12'h008, 32'h0);
    chk("pwmax written", 32'ha, r);
    u_host.set_lines(1'b0, 1'b1);
    cyc(20);
    chk("ovl", 32'h1, {31'h0, ovl});
    chk("emit ovl", 32'h0, {31'h0, emit});
    u_host.set_lines(1'b0, 1'b0);
    cyc(5);
    chk("ovl gate low", 32'h0, {31'h0, ovl});
    apb(1'b1, 12'h008, 32'hc350);
    // a zero duty limit warns over the whole pulse
    apb(1'b1, 12'h00c, 32'h0);
    u_host.set_lines(1'b0, 1'b1);
    cyc(6);
    chk("ovl duty", 32'h1, {31'h0, ovl});
    chk("emit duty", 32'h0, {31'h0, emit});
    u_host.set_lines(1'b0, 1'b0);
    cyc(5);
    apb(1'b1, 12'h00c, 32'h3c);
    $display("test width done");
    // reflection warning, then with protection switched off
    refl_over <= 1'b1;
    u_host.set_lines(1'b0, 1'b1);
    cyc(6);
    chk("refl", 32'h1, {31'h0, refl});
    chk("emit refl", 32'h0, {31'h0, emit});
    refl_over <= 1'b0;
    cyc(5);
    chk("refl gone", 32'h2, {30'h0, emit, refl});
    apb(1'b1, 12'h000, 32'h0);
    refl_over <= 1'b1;
    cyc(5);
    chk("refl unprot", 32'h2, {30'h0, emit, refl});
    refl_over <= 1'b0;
    apb(1'b1, 12'h000, 32'h2);
    $display("test reflection done");
    // latching fault survives its source until enable is cycled
    latch_fault_in <= 1'b1;
    cyc(4);
    chk("emit fault", 32'h0, {31'h0, emit});
    latch_fault_in <= 1'b0;
    cyc(10);
    chk("fault held", 32'h1, {31'h0, system_fault});
    apb(1'b0, 12'h004, 32'h0);
    chk("stat", 32'h1, {31'h0, r[0]});
    u_host.set_lines(1'b1, 1'b0);
    cyc(5);
    chk("fault open", 32'h1, {31'h0, system_fault});
    u_host.set_lines(1'b0, 1'b0);
    cyc(5);
    chk("fault clr", 32'h0, {31'h0, system_fault});
    u_host.set_lines(1'b0, 1'b1);
    cyc(5);
    chk("emit resume", 32'h1, {31'h0, emit});
    // a software latching fault stops emission and latches
    apb(1'b1, 12'h000, 32'h6);
    cyc(2);
    chk("soft fault", 32'h2, {30'h0, system_fault, emit});
    $display("test fault done");
    finish_test();
  end
endmodule : laser_realtime_control_status_bench
